// File: bench/sgp_board.sv
/* sgp_board: board side of the three ports, pull-ups on open-drain pins.
   assumes a board driver on released port 9 pins and the LCD segment drive. */
`timescale 1ns/1ps
module sgp_board
   import sgp_pkg::*;
(
   input wire logic [2:0] p9_pin_out,
   input wire logic [2:0] p9_pin_oe,
   input wire logic [7:0] pa_pin_oe,
   input wire logic [7:0] pb_pin_oe,
   input wire logic [7:0] lcd_segment_output,
   input wire logic [7:0] lcd_segment_oe,
   input wire logic [2:0] p9_ext,
   input wire logic [7:0] pa_ext,
   output logic [2:0] p9_pin_in,
   output logic [7:0] pa_pin_in,
   output logic [7:0] pb_pin_in
);
   // a released port 9 pin shows the board driver, never the last driven level
   assign p9_pin_in = (p9_pin_oe & p9_pin_out) | (~p9_pin_oe & p9_ext);
   // wired-and: a pull-low from the block wins over pull-up, board and segment drive
   assign pa_pin_in = ~pa_pin_oe & ((lcd_segment_oe & lcd_segment_output) |
                                    (~lcd_segment_oe & pa_ext));
   assign pb_pin_in = ~pb_pin_oe;
endmodule

// File: bench/sgp_ports_checker.sv
/* sgp_ports_checker: bus handshake and pin-drive assertions for sgp_ports.
   assumes one clock and a synchronous active-high reset; bound below. */
`timescale 1ns/1ps
module sgp_ports_checker
   import sgp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [2:0] p9_pin_oe,
   input wire logic [7:0] pa_pin_oe,
   input wire logic [7:0] pb_pin_oe,
   input wire logic [7:0] lcd_segment_oe,
   input wire logic [3:0] lcd_common_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_take; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_take: assert property (p_take) else $error("request not answered");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("answer longer than a cycle");
   property p_rdata; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
   a_rdata: assert property (p_rdata) else $error("read data above byte");
   property p_rst; $fell(rst) |-> (p9_pin_oe | pa_pin_oe | pb_pin_oe) == 8'h00
      && lcd_segment_oe == 8'hff; endproperty
   a_rst: assert property (p_rst) else $error("pins driven after reset");
   property p_seg; (pa_pin_oe & lcd_segment_oe) == 8'h00; endproperty
   a_seg: assert property (p_seg) else $error("segment pin pulled low");
   property p_com; (pb_pin_oe[7:4] & lcd_common_oe) == 4'h0; endproperty
   a_com: assert property (p_com) else $error("common pin pulled low");
   // a port 9 pin driver only switches on two cycles after a register write was taken
   property p_cause; (p9_pin_oe & ~$past(p9_pin_oe)) != 3'h0 |-> $past(avs_write, 2); endproperty
   a_cause: assert property (p_cause) else $error("drive without write");
   property p_selch; $changed(lcd_segment_oe) |-> $past(avs_write, 2); endproperty
   a_selch: assert property (p_selch) else $error("segment mode without write");
endmodule
bind sgp_ports sgp_ports_checker u_chk (.*);

// File: bench/sgp_ports_tb.sv
/* sgp_ports_tb: drives sgp_ports over Avalon-MM and checks registers and pins.
   assumes sgp_board and the bound checker are compiled first. */
`timescale 1ns/1ps
module sgp_ports_tb
   import sgp_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [9:0] avs_address = 10'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hf, lcd_common_output = 4'h0, lcd_common_oe;
   logic [2:0] p9_pin_in, p9_pin_out, p9_pin_oe, analog_channel_route, p9_digital_in;
   logic [2:0] p9_ext = 3'h2;
   logic [7:0] pa_pin_in, pa_pin_out, pa_pin_oe, pb_pin_in, pb_pin_out, pb_pin_oe, q;
   logic [7:0] lcd_segment_oe, pa_digital_in, pb_digital_in, pa_ext = 8'hff;
   logic [7:0] lcd_segment_output = 8'h3c;
   logic [1:0] dac_output_pin = 2'h1;
   int errors = 0, checks = 0, cyc = 0;
   sgp_ports dut (.*);
   sgp_board u_board (.*);
   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) if (cyc == 2000) stop_test();
   task stop_test;
      if (cyc >= 2000) errors++;
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // called right after a rising edge; the answer is taken at the edge that sees waitrequest low
   task acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // one idle edge so a following call never re-raises in the same time step
      @(posedge clk);
   endtask
   task rd(input logic [7:0] idx, input logic [7:0] exp);
      acc(1'b0, idx, 8'h00);
      chk(q, exp);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(SGP_IDX_AIN_EN, 8'h07);
      rd(8'h7f, 8'h00);
      acc(1'b1, SGP_IDX_AIN_EN, 8'h00);
      acc(1'b1, SGP_IDX_P9_DATA, 8'h05);
      rd(SGP_IDX_P9_DATA, 8'h02);
      @(posedge clk) rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({lcd_common_oe, lcd_segment_oe[3:0]}, 8'hff);
      acc(1'b1, SGP_IDX_P9_DIR, 8'h07);
      chk({2'h0, p9_pin_oe, p9_pin_out}, 8'h3d);
      rd(SGP_IDX_P9_DATA, 8'h05);
      chk({5'h0, analog_channel_route}, 8'h01);
      acc(1'b1, SGP_IDX_DAC_EN, 8'h03);
      acc(1'b1, SGP_IDX_P9_DIR, 8'h00);
      chk({2'h0, p9_pin_oe, p9_pin_out & p9_pin_oe}, 8'h32);
      acc(1'b1, SGP_IDX_LCD_SEL_A, 8'hff);
      @(posedge clk) pa_ext <= 8'h3f;
      acc(1'b1, SGP_IDX_PA_DATA, 8'hf0);
      chk(pa_pin_oe, 8'h0f);
      rd(SGP_IDX_PA_DATA, 8'h30);
      chk(pa_digital_in, 8'h30);
      acc(1'b1, SGP_IDX_LCD_SEL_A, 8'h0f);
      chk(lcd_segment_oe, 8'hf0);
      rd(SGP_IDX_PA_DATA, 8'hf0);
      acc(1'b1, SGP_IDX_LCD_SEL_B, 8'hff);
      acc(1'b1, SGP_IDX_PB_DATA, 8'h3c);
      chk(pb_pin_oe, 8'hc3);
      chk({4'h0, lcd_common_oe}, 8'h00);
      chk(pa_pin_out | pb_pin_out, 8'h00);
      rd(SGP_IDX_PB_DATA, 8'h30);
      chk(pb_digital_in, 8'h30);
      acc(1'b1, SGP_IDX_AIN_EN, 8'h00);
      acc(1'b1, SGP_IDX_STBY, 8'h03);
      @(posedge clk) p9_ext <= 3'h5;
      repeat (3) @(posedge clk);
      chk({5'h0, p9_digital_in}, 8'h02);
      chk(pa_pin_oe | pb_pin_oe | {5'h0, p9_pin_oe}, 8'h00);
      stop_test();
   end
endmodule

// File: hdl/sgp_pkg.sv
/*
 holds the shared constants, register map and carrier structs of the three small ports:
 port 9 (three push-pull pins shared with one analog input and two converter outputs),
 port A (eight open-drain pins shared with LCD segments) and port B (eight open-drain pins
 shared with LCD bias inputs and common outputs).
 assumes a single 25 MHz clock, a synchronous active-high reset and an Avalon-MM master.
*/
// Behaviour
// - port 9 direction one drives the latch out
// - port 9 direction zero floats the pin
// - port 9 data write always updates the latch
// - enabled converter output overrides direction and data
// - reset clears every port 9 direction bit
// - reset leaves the port 9 latch unchanged
// - reset sets the analog input enables
// - standby float blocks port 9 input, floats pins
// - port A has eight open-drain pins, bit n
// - port A zero pulls low, one releases
// - bit set and clear read the latch
// - port A read returns pin levels unless segment
// - port A select zero segment, one general port
// - general output pin never carries segment output
// - standby float hits port A except segment pins
// - port B: 0-3 output-only bias, 4-7 common
// - port 9 read returns the pin levels (code: drive value on driven pins, 0 on analog-enabled ones)
// - port B select zero means LCD use
package sgp_pkg;
   localparam int unsigned SGP_ADDR_W = 8;
   // word index of each register; byte address is four times the index
   localparam logic [7:0] SGP_IDX_P9_DATA = 8'h29;
   localparam logic [7:0] SGP_IDX_P9_DIR = 8'h2a;
   localparam logic [7:0] SGP_IDX_AIN_EN = 8'h2d;
   localparam logic [7:0] SGP_IDX_PA_DATA = 8'h15;
   localparam logic [7:0] SGP_IDX_LCD_SEL_A = 8'h16;
   localparam logic [7:0] SGP_IDX_PB_DATA = 8'h17;
   localparam logic [7:0] SGP_IDX_LCD_SEL_B = 8'h18;
   localparam logic [7:0] SGP_IDX_STBY = 8'h40;
   localparam logic [7:0] SGP_IDX_DAC_EN = 8'h41;
   localparam logic [2:0] SGP_P9_DIR_RST = 3'h0;
   localparam logic [2:0] SGP_P9_LATCH_RST = 3'h0;
   localparam logic [2:0] SGP_AIN_EN_RST = 3'h7;
   localparam logic [7:0] SGP_PA_DATA_RST = 8'hff;
   localparam logic [7:0] SGP_PB_DATA_RST = 8'hff;
   localparam logic [7:0] SGP_LCD_SEL_RST = 8'h00;
   localparam logic [1:0] SGP_DAC_EN_RST = 2'h0;
   localparam logic [2:0] SGP_STBY_RST = 3'h0;
   // only pin 0 carries the analog input
   localparam logic [2:0] SGP_AIN_ROUTE_MASK = 3'h1;
   // standby register fields
   localparam int unsigned SGP_STBY_FLOAT_BIT = 0;
   localparam int unsigned SGP_STBY_STOP_BIT = 1;
   localparam int unsigned SGP_STBY_WATCH_BIT = 2;
   // port B split: low nibble output-only bias, high nibble two-way common
   localparam logic [7:0] SGP_PB_READ_MASK = 8'hf0;
   localparam logic [2:0] SGP_P9_FIX_LEVEL = 3'h0;
   localparam logic [7:0] SGP_PX_FIX_LEVEL = 8'h00;
   localparam logic [31:0] SGP_RD_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic [2:0] p9_dir;
      logic [2:0] p9_latch;
      logic [2:0] ain_en;
      logic [1:0] dac_en;
      logic [7:0] pa_data;
      logic [7:0] lcd_sel_a;
      logic [7:0] pb_data;
      logic [7:0] lcd_sel_b;
      logic [2:0] stby;
   } sgp_regs_t;

   typedef struct packed {
      logic [2:0] p9_out;
      logic [2:0] p9_oe;
      logic [7:0] pa_out;
      logic [7:0] pa_oe;
      logic [7:0] pb_out;
      logic [7:0] pb_oe;
      logic [7:0] seg_oe;
      logic [3:0] com_oe;
      logic [2:0] ain_route;
   } sgp_pins_t;

   typedef struct packed {
      sgp_regs_t regs;
      sgp_pins_t pins;
      logic [31:0] rdata;
      logic rvalid_wait;
      logic [2:0] p9_in_held;
      logic [7:0] pa_in_held;
      logic [7:0] pb_in_held;
   } sgp_state_t;
endpackage

// File: hdl/sgp_ports.sv
/*
 holds the port logic for port 9, port A and port B behind an Avalon-MM slave.
 assumes pins are resolved outside from the out and oe signals, pin inputs are synchronous,
 and the LCD and converter blocks present their own drive on the segment, common and dac inputs.
*/
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
module sgp_ports
   import sgp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [SGP_ADDR_W+1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [2:0] p9_pin_in,
   output logic [2:0] p9_pin_out,
   output logic [2:0] p9_pin_oe,
   input wire logic [7:0] pa_pin_in,
   output logic [7:0] pa_pin_out,
   output logic [7:0] pa_pin_oe,
   input wire logic [7:0] pb_pin_in,
   output logic [7:0] pb_pin_out,
   output logic [7:0] pb_pin_oe,
   input wire logic [1:0] dac_output_pin,
   input wire logic [7:0] lcd_segment_output,
   input wire logic [3:0] lcd_common_output,
   output logic [7:0] lcd_segment_oe,
   output logic [3:0] lcd_common_oe,
   output logic [2:0] analog_channel_route,
   output logic [2:0] p9_digital_in,
   output logic [7:0] pa_digital_in,
   output logic [7:0] pb_digital_in
);

   sgp_state_t cur_ff;
   sgp_state_t nxt_cur;

   function automatic logic [7:0] sgp_byte(input logic [31:0] wd, input logic [3:0] be,
                                           input logic [7:0] old);
      sgp_byte = be[0] ? wd[7:0] : old;
   endfunction

   function automatic logic sgp_hit(input logic [SGP_ADDR_W+1:0] a, input logic [7:0] idx);
      sgp_hit = (a[SGP_ADDR_W+1:2] == idx) && (a[1:0] == 2'h0);
   endfunction

   logic standby_float;
   logic [2:0] p9_drive_oe;
   logic [2:0] p9_drive_val;
   logic [7:0] pa_in_now;
   logic [7:0] pb_in_now;
   logic [2:0] p9_in_now;
   logic [31:0] rd_val;

   always_comb begin
      standby_float = cur_ff.regs.stby[SGP_STBY_FLOAT_BIT] &&
                      (cur_ff.regs.stby[SGP_STBY_STOP_BIT] ||
                       cur_ff.regs.stby[SGP_STBY_WATCH_BIT]);
      // pin 0 has no converter; pins 1 and 2 follow the two converter enables
      p9_drive_oe = cur_ff.regs.p9_dir;
      p9_drive_val = cur_ff.regs.p9_latch;
      for (int i = 1; i < 3; i++) begin
         if (cur_ff.regs.dac_en[i-1]) begin
            p9_drive_oe[i] = 1'b1;
            p9_drive_val[i] = dac_output_pin[i-1];
         end
      end
      if (standby_float) begin
         p9_drive_oe = SGP_P9_FIX_LEVEL;
      end
      // inputs except port A segment pins are frozen in standby float so floating pins cause no toggling inside
      p9_in_now = standby_float ? cur_ff.p9_in_held : (p9_pin_in & ~cur_ff.regs.ain_en);
      pa_in_now = pa_pin_in;
      for (int i = 0; i < 8; i++) begin
         if (standby_float && cur_ff.regs.lcd_sel_a[i]) begin
            pa_in_now[i] = cur_ff.pa_in_held[i];
         end
      end
      pb_in_now = standby_float ? cur_ff.pb_in_held : (pb_pin_in & SGP_PB_READ_MASK);
      rd_val = SGP_RD_ZERO;
      if (sgp_hit(avs_address, SGP_IDX_P9_DATA)) begin
         rd_val[2:0] = p9_in_now;
         for (int i = 0; i < 3; i++) begin
            if (p9_drive_oe[i]) begin
               rd_val[i] = p9_drive_val[i];
            end
         end
      end else if (sgp_hit(avs_address, SGP_IDX_P9_DIR)) begin
         rd_val[2:0] = cur_ff.regs.p9_dir;
      end else if (sgp_hit(avs_address, SGP_IDX_AIN_EN)) begin
         rd_val[2:0] = cur_ff.regs.ain_en;
      end else if (sgp_hit(avs_address, SGP_IDX_DAC_EN)) begin
         rd_val[1:0] = cur_ff.regs.dac_en;
      end else if (sgp_hit(avs_address, SGP_IDX_PA_DATA)) begin
         // segment pins read their latch, so a read-modify-write leaves them untouched
         rd_val[7:0] = (pa_in_now & cur_ff.regs.lcd_sel_a) |
                       (cur_ff.regs.pa_data & ~cur_ff.regs.lcd_sel_a);
      end else if (sgp_hit(avs_address, SGP_IDX_LCD_SEL_A)) begin
         rd_val[7:0] = cur_ff.regs.lcd_sel_a;
      end else if (sgp_hit(avs_address, SGP_IDX_PB_DATA)) begin
         rd_val[7:0] = pb_in_now & cur_ff.regs.lcd_sel_b & SGP_PB_READ_MASK;
      end else if (sgp_hit(avs_address, SGP_IDX_LCD_SEL_B)) begin
         rd_val[7:0] = cur_ff.regs.lcd_sel_b;
      end else if (sgp_hit(avs_address, SGP_IDX_STBY)) begin
         rd_val[2:0] = cur_ff.regs.stby;
      end
   end

   always_comb begin
      nxt_cur = cur_ff;
      // two-phase handshake: accept in cycle 0, answer with waitrequest low in cycle 1
      nxt_cur.rvalid_wait = (avs_read || avs_write) && !cur_ff.rvalid_wait;
      if (avs_read && !cur_ff.rvalid_wait) begin
         nxt_cur.rdata = rd_val;
      end
      if (avs_write && !cur_ff.rvalid_wait && avs_byteenable[0]) begin
         if (sgp_hit(avs_address, SGP_IDX_P9_DATA)) begin
            nxt_cur.regs.p9_latch = avs_writedata[2:0];
         end
         if (sgp_hit(avs_address, SGP_IDX_P9_DIR)) begin
            nxt_cur.regs.p9_dir = avs_writedata[2:0];
         end
         if (sgp_hit(avs_address, SGP_IDX_AIN_EN)) begin
            nxt_cur.regs.ain_en = avs_writedata[2:0];
         end
         if (sgp_hit(avs_address, SGP_IDX_DAC_EN)) begin
            nxt_cur.regs.dac_en = avs_writedata[1:0];
         end
         if (sgp_hit(avs_address, SGP_IDX_PA_DATA)) begin
            nxt_cur.regs.pa_data = sgp_byte(avs_writedata, avs_byteenable,
                                            cur_ff.regs.pa_data);
         end
         if (sgp_hit(avs_address, SGP_IDX_LCD_SEL_A)) begin
            nxt_cur.regs.lcd_sel_a = avs_writedata[7:0];
         end
         if (sgp_hit(avs_address, SGP_IDX_PB_DATA)) begin
            nxt_cur.regs.pb_data = avs_writedata[7:0];
         end
         if (sgp_hit(avs_address, SGP_IDX_LCD_SEL_B)) begin
            nxt_cur.regs.lcd_sel_b = avs_writedata[7:0];
         end
         if (sgp_hit(avs_address, SGP_IDX_STBY)) begin
            nxt_cur.regs.stby = avs_writedata[2:0];
         end
      end
      nxt_cur.p9_in_held = p9_in_now;
      nxt_cur.pa_in_held = pa_in_now;
      nxt_cur.pb_in_held = pb_in_now;
      nxt_cur.pins.p9_out = p9_drive_val;
      nxt_cur.pins.p9_oe = p9_drive_oe;
      // analog path only reaches the converter with both direction and enable set
      nxt_cur.pins.ain_route = cur_ff.regs.p9_dir & cur_ff.regs.ain_en &
                               SGP_AIN_ROUTE_MASK;
      for (int i = 0; i < 8; i++) begin
         // open drain: only ever drives low
         nxt_cur.pins.pa_out[i] = 1'b0;
         nxt_cur.pins.pa_oe[i] = cur_ff.regs.lcd_sel_a[i] && !cur_ff.regs.pa_data[i] &&
                                 !standby_float;
         nxt_cur.pins.seg_oe[i] = !cur_ff.regs.lcd_sel_a[i];
         nxt_cur.pins.pb_out[i] = 1'b0;
         nxt_cur.pins.pb_oe[i] = cur_ff.regs.lcd_sel_b[i] && !cur_ff.regs.pb_data[i] &&
                                 !standby_float;
      end
      for (int i = 0; i < 4; i++) begin
         nxt_cur.pins.com_oe[i] = !cur_ff.regs.lcd_sel_b[i+4];
      end
      if (rst) begin
         nxt_cur.regs.p9_dir = SGP_P9_DIR_RST;
         nxt_cur.regs.ain_en = SGP_AIN_EN_RST;
         nxt_cur.regs.dac_en = SGP_DAC_EN_RST;
         nxt_cur.regs.pa_data = SGP_PA_DATA_RST;
         nxt_cur.regs.pb_data = SGP_PB_DATA_RST;
         nxt_cur.regs.lcd_sel_a = SGP_LCD_SEL_RST;
         nxt_cur.regs.lcd_sel_b = SGP_LCD_SEL_RST;
         nxt_cur.regs.stby = SGP_STBY_RST;
         // port 9 latch deliberately kept across reset
         nxt_cur.regs.p9_latch = cur_ff.regs.p9_latch;
         nxt_cur.rvalid_wait = 1'b0;
         nxt_cur.rdata = SGP_RD_ZERO;
         nxt_cur.pins.p9_oe = SGP_P9_DIR_RST;
         nxt_cur.pins.pa_oe = SGP_PX_FIX_LEVEL;
         nxt_cur.pins.pb_oe = SGP_PX_FIX_LEVEL;
         // lcd owns the shared pins from the first reset edge, not one cycle later
         nxt_cur.pins.seg_oe = ~SGP_LCD_SEL_RST;
         nxt_cur.pins.com_oe = ~SGP_LCD_SEL_RST[7:4];
      end
   end

   always_ff @(posedge clk) begin
      cur_ff <= nxt_cur;
   end

   assign avs_readdata = cur_ff.rdata;
   assign avs_waitrequest = !cur_ff.rvalid_wait;
   assign p9_pin_out = cur_ff.pins.p9_out;
   assign p9_pin_oe = cur_ff.pins.p9_oe;
   assign pa_pin_out = cur_ff.pins.pa_out;
   assign pa_pin_oe = cur_ff.pins.pa_oe;
   assign pb_pin_out = cur_ff.pins.pb_out;
   assign pb_pin_oe = cur_ff.pins.pb_oe;
   assign lcd_segment_oe = cur_ff.pins.seg_oe;
   assign lcd_common_oe = cur_ff.pins.com_oe;
   assign analog_channel_route = cur_ff.pins.ain_route;
   assign p9_digital_in = cur_ff.p9_in_held;
   assign pa_digital_in = cur_ff.pa_in_held;
   assign pb_digital_in = cur_ff.pb_in_held;
endmodule
